// file: common/mdswr_pkg.sv
// Constants shared by the status word reporter and its serial sender.
// Assumes a single 50 MHz clock and a 32-bit classic Wishbone register bus.
package mdswr_pkg;
  localparam int CLK_MHZ      = 50;
  localparam int BIT_TIME_NS  = 20000;
  localparam int BIT_CYC      = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int REQ_TIME_NS  = 40000;
  localparam int REQ_CYC      = (REQ_TIME_NS * CLK_MHZ + 999) / 1000;

  localparam int WORD_W  = 7;
  localparam int FRAME_W = 8;
  localparam int ADR_W   = 8;

  localparam logic [ADR_W-1:0] ADR_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] ADR_STATUS   = 8'h04;
  localparam logic [ADR_W-1:0] ADR_LAST     = 8'h08;
  localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h10;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_ODD_BIT = 1;
  localparam int CTRL_REQ_BIT = 2;
  localparam logic [1:0] CTRL_RST = 2'h1;

  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_SW_BIT   = 9;

  localparam int IRQ_W        = 3;
  localparam int IRQ_SENT_BIT = 0;
  localparam int IRQ_FLT_BIT  = 1;
  localparam int IRQ_REQ_BIT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Field positions inside the status word.
  localparam int FA_LSB = 0;
  localparam int FB_LSB = 3;
  localparam int LS_OC_BIT = 5;
  localparam int HS_OC_BIT = 6;

  // Field codes as word bits, bit 0 at the right.
  localparam logic [2:0] FA_NONE  = 3'h0;
  localparam logic [2:0] FA_OV    = 3'h4;
  localparam logic [2:0] FA_UV100 = 3'h2;
  localparam logic [2:0] FA_UV85  = 3'h6;
  localparam logic [2:0] FA_UV70  = 3'h1;
  localparam logic [2:0] FA_UV55  = 3'h5;
  localparam logic [2:0] FA_SYSOT = 3'h3;
  localparam logic [2:0] FA_LSNR  = 3'h7;
  localparam logic [1:0] FB_NONE  = 2'h0;
  localparam logic [1:0] FB_WARN  = 2'h2;
  localparam logic [1:0] FB_SHUT  = 2'h1;
  localparam logic [1:0] FB_HSNR  = 2'h3;

  // Undervoltage level input encoding.
  localparam logic [2:0] UV_NONE = 3'h0;
  localparam logic [2:0] UV_100  = 3'h1;
  localparam logic [2:0] UV_85   = 3'h2;
  localparam logic [2:0] UV_70   = 3'h3;
  localparam logic [2:0] UV_55   = 3'h4;

  localparam logic [WORD_W-1:0] READY_WORD = 7'h00;
endpackage : mdswr_pkg

// file: rtl/mdswr_tx.sv
// Serial sender for one status frame on the open-drain status line.
// Assumes the caller pulses start only while busy is low.
`timescale 1ns/1ns
`default_nettype none
module mdswr_tx #(
  parameter int BIT_CYC = mdswr_pkg::BIT_CYC
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           start_i,
  input  wire logic [mdswr_pkg::FRAME_W-1:0]  frame_i,
  output logic                                busy_o,
  output logic                                oe_o,
  output logic                                done_o
);
  import mdswr_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} mdswr_tx_st_t;

  mdswr_tx_st_t         st_ff;
  logic [FRAME_W-1:0]   sh_ff;
  logic [3:0]           idx_ff;
  logic [15:0]          cnt_ff;
  logic                 cell_end;

  assign cell_end = (cnt_ff == 16'(BIT_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
    end else if (st_ff == S_IDLE || cell_end) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // A zero pulls the line low, a one releases it; the start cell is low and
  // the stop cell released, so the listener can frame every word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff  <= S_IDLE;
      sh_ff  <= 8'h00;
      idx_ff <= 4'h0;
      oe_o   <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (start_i) begin
            st_ff  <= S_START;
            sh_ff  <= frame_i;
            idx_ff <= 4'h0;
            oe_o   <= 1'b1;
            busy_o <= 1'b1;
          end
        end
        S_START: begin
          if (cell_end) begin
            st_ff <= S_DATA;
            oe_o  <= ~sh_ff[0];
          end
        end
        S_DATA: begin
          if (cell_end) begin
            if (idx_ff == 4'(FRAME_W - 1)) begin
              st_ff <= S_STOP;
              oe_o  <= 1'b0;
            end else begin
              idx_ff <= idx_ff + 4'h1;
              oe_o   <= ~sh_ff[idx_ff[2:0] + 3'h1];
            end
          end
        end
        S_STOP: begin
          if (cell_end) begin
            st_ff  <= S_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default: begin
          st_ff  <= S_IDLE;
          oe_o   <= 1'b0;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  a_data_order: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_DATA) |-> (oe_o == ~sh_ff[idx_ff[2:0]]))
    else $error("data cell does not match frame bit");
  a_stop_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff == S_STOP || st_ff == S_IDLE) |-> !oe_o)
    else $error("line held low outside start or data cells");
endmodule : mdswr_tx
`default_nettype wire

// file: rtl/mdswr_top.sv
// Status word reporter: encodes fault conditions into a 7-bit word plus
// parity and sends it on a shared open-drain line, with a Wishbone slave.
// Assumes condition inputs and the line input are synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Seven status bits followed by one parity bit.
// - Bits 0-2 carry overvoltage, undervoltage, system thermal.
// - Low-side driver not ready is 111.
// - Bits 3-4 carry thermal warning and shutdown.
// - High-side driver not ready is 11.
// - Independent fields; bits 5, 6 over-current.
// - Fields reported together, no priority queue.
// - Ready word after power-up completes.
// - Ready word when a fault clears.
// - Status request answered, ready word if clean.
// - Line only pulled low or released.
// - System sense threshold reported as thermal fault.
// - Overvoltage stops switching until below hysteresis.
module mdswr_top #(
  parameter int  BIT_CYC  = mdswr_pkg::BIT_CYC,
  parameter int  REQ_CYC  = mdswr_pkg::REQ_CYC,
  parameter logic ODD_RST = 1'b0
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [mdswr_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          bus_ov_above_i,
  input  wire logic                          bus_ov_below_hyst_i,
  input  wire logic [2:0]                    bus_uv_level_i,
  input  wire logic                          system_sense_input_i,
  input  wire logic                          ls_not_ready_i,
  input  wire logic                          ls_therm_warn_i,
  input  wire logic                          ls_therm_shut_i,
  input  wire logic                          hs_not_ready_i,
  input  wire logic                          ls_oc_i,
  input  wire logic                          hs_oc_i,
  input  wire logic                          status_line_i,
  output logic                               status_line_o,
  output logic                               status_line_oe_o,
  output logic                               switch_en_o,
  output logic                               irq_o
);
  import mdswr_pkg::*;

  logic                 en_ff;
  logic                 odd_ff;
  logic                 ov_ff;
  logic [WORD_W-1:0]    word_ff;
  logic [WORD_W-1:0]    sent_word_ff;
  logic [FRAME_W-1:0]   frame_ff;
  logic                 start_ff;
  logic                 pu_pend_ff;
  logic                 req_pend_ff;
  logic [15:0]          low_cnt_ff;
  logic                 req_seen_ff;
  logic [IRQ_W-1:0]     irq_stat_ff;
  logic [IRQ_W-1:0]     irq_mask_ff;
  logic                 tx_busy;
  logic                 tx_done;
  logic                 wb_req;
  logic                 wb_wr;
  logic                 sw_req;
  logic                 pend;
  logic                 launch;
  logic                 new_fault;
  logic [WORD_W-1:0]    nxt_word;
  logic [IRQ_W-1:0]     irq_evt;

  // Within a field only one code can stand; should two conditions of one
  // field coincide, the more severe one is shown.
  function automatic logic [2:0] enc_field_a(input logic ls_nr, input logic ov,
                                             input logic sys_ot,
                                             input logic [2:0] uv);
    if (ls_nr) begin
      return FA_LSNR;
    end else if (ov) begin
      return FA_OV;
    end else if (sys_ot) begin
      return FA_SYSOT;
    end else begin
      case (uv)
        UV_100:  return FA_UV100;
        UV_85:   return FA_UV85;
        UV_70:   return FA_UV70;
        UV_55:   return FA_UV55;
        default: return FA_NONE;
      endcase
    end
  endfunction : enc_field_a

  function automatic logic [1:0] enc_field_b(input logic hs_nr, input logic shut,
                                             input logic warn);
    if (hs_nr) begin
      return FB_HSNR;
    end else if (shut) begin
      return FB_SHUT;
    end else if (warn) begin
      return FB_WARN;
    end else begin
      return FB_NONE;
    end
  endfunction : enc_field_b

  function automatic logic parity_of(input logic [WORD_W-1:0] w, input logic odd);
    return (^w) ^ odd;
  endfunction : parity_of

  // Overvoltage latches on the upper threshold and releases only once the
  // bus is back below the threshold less hysteresis.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_ff       <= 1'b0;
      switch_en_o <= 1'b0;
    end else begin
      if (bus_ov_above_i) begin
        ov_ff <= 1'b1;
      end else if (bus_ov_below_hyst_i) begin
        ov_ff <= 1'b0;
      end
      switch_en_o <= !bus_ov_above_i && !(ov_ff && !bus_ov_below_hyst_i);
    end
  end

  // Each field is built on its own, so several faults share one word.
  always_comb begin
    nxt_word                          = READY_WORD;
    nxt_word[FA_LSB +: 3]             = enc_field_a(ls_not_ready_i,
                                          bus_ov_above_i || ov_ff,
                                          system_sense_input_i,
                                          bus_uv_level_i);
    nxt_word[FB_LSB +: 2]             = enc_field_b(hs_not_ready_i, ls_therm_shut_i,
                                                    ls_therm_warn_i);
    nxt_word[LS_OC_BIT]               = ls_oc_i;
    nxt_word[HS_OC_BIT]               = hs_oc_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_ff <= READY_WORD;
    end else begin
      word_ff <= nxt_word;
    end
  end

  // A request is the controller holding the line low for at least REQ_CYC
  // cycles and releasing it. Our own frames are not counted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_cnt_ff  <= 16'h0000;
      req_seen_ff <= 1'b0;
    end else begin
      req_seen_ff <= 1'b0;
      if (tx_busy || start_ff) begin
        low_cnt_ff <= 16'h0000;
      end else if (!status_line_i) begin
        if (low_cnt_ff != 16'(REQ_CYC)) begin
          low_cnt_ff <= low_cnt_ff + 16'h0001;
        end
      end else begin
        req_seen_ff <= (low_cnt_ff == 16'(REQ_CYC));
        low_cnt_ff  <= 16'h0000;
      end
    end
  end

  assign pend   = pu_pend_ff || req_pend_ff || (word_ff != sent_word_ff);
  assign launch = en_ff && pend && !tx_busy && !start_ff;

  // Pending reports are flags, not a queue: a launch always sends the word
  // as it stands, so stale faults are never replayed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pu_pend_ff   <= 1'b1;
      req_pend_ff  <= 1'b0;
      sent_word_ff <= READY_WORD;
      frame_ff     <= 8'h00;
      start_ff     <= 1'b0;
    end else begin
      start_ff <= launch;
      if (launch) begin
        pu_pend_ff   <= 1'b0;
        sent_word_ff <= word_ff;
        frame_ff     <= {parity_of(word_ff, odd_ff), word_ff};
      end
      if (req_seen_ff || sw_req) begin
        req_pend_ff <= 1'b1;
      end else if (launch) begin
        req_pend_ff <= 1'b0;
      end
    end
  end

  mdswr_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (start_ff),
    .frame_i (frame_ff),
    .busy_o  (tx_busy),
    .oe_o    (status_line_oe_o),
    .done_o  (tx_done)
  );

  // The line is never driven high; the pull-up supplies the one level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_line_o <= 1'b0;
    end else begin
      status_line_o <= 1'b0;
    end
  end

  // Ack is registered, so every access costs one wait state; masking the request
  // with ack keeps a master that is slow to drop stb from being served twice.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  assign sw_req = wb_wr && (wb_adr_i == ADR_CTRL) && wb_dat_i[CTRL_REQ_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADR_CTRL:     wb_dat_o <= {30'h0, odd_ff, en_ff};
          ADR_STATUS:   wb_dat_o <= {22'h0, switch_en_o, tx_busy, 1'b0, word_ff};
          ADR_LAST:     wb_dat_o <= {24'h0, frame_ff};
          ADR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_ff};
          ADR_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_ff};
          default:      wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff       <= CTRL_RST[CTRL_EN_BIT];
      odd_ff      <= ODD_RST;
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        en_ff  <= wb_dat_i[CTRL_EN_BIT];
        odd_ff <= wb_dat_i[CTRL_ODD_BIT];
      end
      if (wb_adr_i == ADR_IRQ_MASK) begin
        irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  assign new_fault = (word_ff != READY_WORD) && (word_ff != sent_word_ff) && launch;
  assign irq_evt   = {req_seen_ff, new_fault, tx_done};

  // Write one to clear; an event in the same cycle keeps its bit set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 3'h0;
      irq_o       <= 1'b0;
    end else begin
      if (wb_wr && wb_adr_i == ADR_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // The word is registered, so field checks look one cycle after the inputs.
  a_frame_parity: assert property (
    launch |=> (frame_ff[WORD_W] == ((^frame_ff[WORD_W-1:0]) ^ $past(odd_ff))))
    else $error("parity bit wrong for launched word");
  a_ov_code: assert property (
    (bus_ov_above_i && !ls_not_ready_i) |=> (word_ff[2:0] == FA_OV))
    else $error("overvoltage not encoded in bits 0 to 2");
  a_lsnr_code: assert property (
    ls_not_ready_i |=> (word_ff[2:0] == FA_LSNR))
    else $error("low-side not ready not encoded as all ones");
  a_hsnr_code: assert property (
    hs_not_ready_i |=> (word_ff[4:3] == FB_HSNR))
    else $error("high-side not ready not encoded");
  a_warn_code: assert property (
    (ls_therm_warn_i && !ls_therm_shut_i && !hs_not_ready_i) |=> (word_ff[FB_LSB +: 2] == FB_WARN))
    else $error("thermal warning not encoded in bits 3 and 4");
  a_shut_code: assert property (
    (ls_therm_shut_i && !hs_not_ready_i) |=> (word_ff[FB_LSB +: 2] == FB_SHUT))
    else $error("thermal shutdown not encoded in bits 3 and 4");
  a_uv_code: assert property (
    (bus_uv_level_i == UV_55 && !ls_not_ready_i && !bus_ov_above_i && !ov_ff
      && !system_sense_input_i) |=> (word_ff[FA_LSB +: 3] == FA_UV55))
    else $error("lowest undervoltage level not encoded");
  a_oc_bits: assert property (
    ##1 (word_ff[LS_OC_BIT] == $past(ls_oc_i) && word_ff[HS_OC_BIT] == $past(hs_oc_i)))
    else $error("over-current bits do not follow inputs");
  a_sense_code: assert property (
    (system_sense_input_i && !ls_not_ready_i && !bus_ov_above_i && !ov_ff)
      |=> (word_ff[2:0] == FA_SYSOT))
    else $error("system sense threshold not reported");
  a_ov_stop: assert property (
    bus_ov_above_i |=> !switch_en_o [*2])
    else $error("switching not stopped on overvoltage");
  a_clear_ready: assert property (
    (en_ff && !tx_busy && !start_ff && word_ff == READY_WORD
      && sent_word_ff != READY_WORD) |=> (start_ff && frame_ff[WORD_W-1:0] == READY_WORD))
    else $error("ready word not sent when fault cleared");
  a_req_pend: assert property (
    req_seen_ff |=> req_pend_ff || start_ff)
    else $error("status request lost");
  a_line_low_only: assert property (
    !status_line_o)
    else $error("line driven high");
  a_ack_pulse: assert property (
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  c_ready_sent: cover property (launch && word_ff == READY_WORD);
  c_fault_sent: cover property (launch && word_ff[2:0] == FA_OV && word_ff[LS_OC_BIT]);
  c_request: cover property (req_seen_ff ##[1:5] start_ff);
  c_irq: cover property ($rose(irq_o));
  c_soft_request: cover property (sw_req ##[1:4] start_ff);
endmodule : mdswr_top
`default_nettype wire

// file: test/mdswr_mcu_model.sv
// Controller-side model of the shared status line: frame receiver and request source.
// Assumes the bench resolves the line with a pull-up and feeds the level back here.
`timescale 1ns/1ns
`default_nettype none
module mdswr_mcu_model #(
  parameter int BIT_CYC = 4,
  parameter int REQ_CYC = 8
) (
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       req_i,
  output logic            oe_o,
  output logic [7:0]      frame_o,
  output logic [7:0]      count_o
);
  // The model only ever pulls low and then lets the pull-up restore the line.
  initial begin
    oe_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (req_i && !oe_o) begin
        oe_o <= 1'b1;
        repeat (REQ_CYC) @(posedge clk_i);
        oe_o <= 1'b0;
      end
    end
  end

  // Cells are sampled mid-way so that a late edge never decides a bit.
  initial begin
    frame_o = 8'h00;
    count_o = 8'h00;
    forever begin
      @(posedge clk_i);
      if (!line_i && !oe_o) begin
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
          frame_o[k] <= line_i;
          repeat (BIT_CYC) @(posedge clk_i);
        end
        count_o <= count_o + 8'h01;
        wait (line_i);
      end
    end
  end
endmodule : mdswr_mcu_model
`default_nettype wire

// file: test/motor_driver_status_word_reporter_bench.sv
// Self-checking bench for the status word reporter: frames, request, overvoltage, registers.
// Assumes the controller model and short cell and request times for a quick run.
`timescale 1ns/1ns
`default_nettype none
module motor_driver_status_word_reporter_bench;
  import mdswr_pkg::*;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ov_above = 1'b0;
  logic        ov_hyst  = 1'b1;
  logic [2:0]  uv       = 3'h0;
  logic [6:0]  cnd      = 7'h00;
  logic        req      = 1'b0;
  logic        dut_oe;
  logic        dut_lo;
  logic        sw_en;
  logic        irq;
  logic        mcu_oe;
  logic        line;
  logic [7:0]  frame;
  logic [7:0]  cnt;
  logic [7:0]  seen     = 8'h00;
  logic [31:0] q;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles   = 0;

  always #10 clk_i = ~clk_i;
  assign line = (dut_oe ? dut_lo : 1'b1) & ~mcu_oe;

  mdswr_top #(.BIT_CYC(4), .REQ_CYC(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_ov_above_i(ov_above), .bus_ov_below_hyst_i(ov_hyst), .bus_uv_level_i(uv),
    .system_sense_input_i(cnd[0]), .ls_not_ready_i(cnd[1]), .ls_therm_warn_i(cnd[2]),
    .ls_therm_shut_i(cnd[3]), .hs_not_ready_i(cnd[4]), .ls_oc_i(cnd[5]), .hs_oc_i(cnd[6]),
    .status_line_i(line), .status_line_o(dut_lo), .status_line_oe_o(dut_oe),
    .switch_en_o(sw_en), .irq_o(irq));

  mdswr_mcu_model #(.BIT_CYC(4), .REQ_CYC(8)) mcu (
    .clk_i(clk_i), .line_i(line), .req_i(req), .oe_o(mcu_oe), .frame_o(frame),
    .count_o(cnt));

  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1);
    check(k == 2, "bus answer not one cycle after request");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic expect_frame(input logic [6:0] w, input logic odd, input string what);
    int k;
    k = 0;
    while (cnt === seen && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    seen = seen + 8'h01;
    check(k < 400 && frame === {^w ^ odd, w}, what);
  endtask : expect_frame

  task automatic t_regs();
    wb(1'b0, ADR_CTRL, 32'h0);
    check(q[2:0] === 3'h1, "control reset value");
    wb(1'b0, 8'h40, 32'h0);
    check(q === 32'h0, "unmapped read");
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check(q[IRQ_SENT_BIT] === 1'b1 && irq === 1'b0, "sent flag or mask");
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    check(irq === 1'b1, "unmasked interrupt low");
    wb(1'b1, ADR_IRQ_STAT, 32'h7);
    check(irq === 1'b0, "interrupt not cleared");
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
  endtask : t_regs

  // Each row raises one condition alone; the word is written out bit 0 at the right.
  task automatic t_fields();
    logic [9:0] tab [11] = '{10'h080, 10'h100, 10'h180, 10'h200, 10'h001, 10'h002,
                             10'h004, 10'h008, 10'h010, 10'h020, 10'h040};
    logic [6:0] wtab [11] = '{7'h02, 7'h06, 7'h01, 7'h05, 7'h03, 7'h07,
                              7'h10, 7'h08, 7'h18, 7'h20, 7'h40};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      {uv, cnd} <= tab[i];
      expect_frame(wtab[i], 1'b0, "single field word");
      @(posedge clk_i);
      {uv, cnd} <= 10'h000;
      expect_frame(7'h00, 1'b0, "ready after clear");
    end
    @(posedge clk_i);
    uv  <= UV_55;
    cnd <= 7'h68;
    expect_frame(7'h6D, 1'b0, "fields together");
    @(posedge clk_i);
    uv  <= UV_NONE;
    cnd <= 7'h00;
    expect_frame(7'h00, 1'b0, "ready after clear");
  endtask : t_fields

  task automatic t_overvoltage();
    @(posedge clk_i);
    ov_hyst  <= 1'b0;
    ov_above <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(sw_en === 1'b0, "switching not stopped");
    expect_frame(7'h04, 1'b0, "overvoltage word");
    @(posedge clk_i);
    ov_above <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(sw_en === 1'b0, "resumed inside hysteresis");
    @(posedge clk_i);
    ov_hyst <= 1'b1;
    expect_frame(7'h00, 1'b0, "ready after overvoltage");
    check(sw_en === 1'b1, "switching not resumed");
  endtask : t_overvoltage

  task automatic ask();
    @(posedge clk_i);
    req <= 1'b1;
    @(posedge clk_i);
    req <= 1'b0;
  endtask : ask

  task automatic t_request();
    wb(1'b1, ADR_CTRL, 32'h3);
    ask();
    expect_frame(7'h00, 1'b1, "request answer odd parity");
    wb(1'b0, ADR_IRQ_STAT, 32'h0);
    check(q[IRQ_REQ_BIT] === 1'b1, "request not seen");
    wb(1'b1, ADR_CTRL, 32'h1);
    @(posedge clk_i);
    cnd <= 7'h20;
    expect_frame(7'h20, 1'b0, "over-current word");
    ask();
    expect_frame(7'h20, 1'b0, "request answer with fault");
    wb(1'b1, ADR_CTRL, 32'h5);
    expect_frame(7'h20, 1'b0, "software request answer");
    wb(1'b0, ADR_CTRL, 32'h0);
    check(q[2:0] === 3'h1, "request bit not self-clearing");
    wb(1'b0, ADR_STATUS, 32'h0);
    check(q[9:0] === 10'h220, "status register");
    wb(1'b0, ADR_LAST, 32'h0);
    check(q[7:0] === 8'hA0, "last frame register");
    @(posedge clk_i);
    cnd <= 7'h00;
    expect_frame(7'h00, 1'b0, "ready after clear");
  endtask : t_request

  always @(posedge clk_i) begin
    if (!rst_i && dut_oe === 1'b1 && dut_lo !== 1'b0) begin
      n_errors++;
      $display("[ERR] %0t line driven high", $time);
    end
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    expect_frame(7'h00, 1'b0, "power-up ready");
    check(sw_en === 1'b1, "switching off after reset");
    t_regs();
    t_fields();
    t_overvoltage();
    t_request();
    print_verdict();
  end
endmodule : motor_driver_status_word_reporter_bench
`default_nettype wire
